// ==== src/cfm_pin_mux.sv ====
// Function multiplexer for five configurable I/O pins of a serial bridge.
// Assumes the selections arrive from the non-volatile configuration store,
// the 48 MHz clock arrives asynchronously on a pin, and event inputs are on clock.
`timescale 1ns/100ps
// Function
// RQ1: Pin functions come from stored configuration only.
// RQ2: Common functions available on all five pins.
// RQ3: Line driver enable while transmitter sends.
// RQ4: Power enable low when configured, high suspended.
// RQ5: Transmit activity pulses pin low.
// RQ6: Receive activity pulses pin low.
// RQ7: Combined activity pulses low on either.
// RQ8: Suspend indicator low while suspended.
// RQ9: Clock outputs at 48, 24, 12, 6 MHz.
// RQ10: General purpose I/O only on pins 0-3.
// RQ11: Each pin enables GPIO from own entry.
// RQ12: Write strobe pins 0-1, read 0-3.
// RQ13: Defaults: pin0 tx, pin1 rx, pin3 power.
// RQ14: Suspend pull high, or low by option.
// RQ15: LED pulses stretched, retriggered by activity.
module cfm_pin_mux
	import cfm_pkg::*;
#(
	parameter int LED_PULSE_CYCLES = (`CFM_LED_PULSE_NS + `CFM_CLK_NS - 1) / `CFM_CLK_NS,
	parameter int NUM_PINS         = `CFM_NUM_PINS
) (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic                  nvm_valid,
	input  wire logic [4*`CFM_SEL_W-1:0] nvm_pin_select,
	input  wire logic [4:0]            nvm_pin_select_4,
	input  wire logic                  nvm_suspend_pull_low,
	input  wire logic                  clock_in_48m,
	input  wire logic                  uart_tx_active,
	input  wire logic                  usb_configured,
	input  wire logic                  usb_suspend,
	input  wire logic                  usb_tx_event,
	input  wire logic                  usb_rx_event,
	input  wire logic [3:0]            gpio_out,
	input  wire logic [3:0]            gpio_oe,
	input  wire logic                  parallel_wr_n,
	input  wire logic                  parallel_rd_n,
	output logic      [4:0]            pin_out,
	output logic      [4:0]            pin_oe,
	output logic      [4:0]            pin_pull_up,
	output logic      [4:0]            pin_pull_down
);
	localparam int CW = $clog2(LED_PULSE_CYCLES + 1);

	// Refuse sizes the fixed five-pin logic cannot serve
	if (NUM_PINS != `CFM_NUM_PINS || LED_PULSE_CYCLES < 1) begin : g_bad_param
		$error("cfm_pin_mux: unsupported parameters");
	end

	typedef struct packed {
		cfm_sel_type [4:0] sel;
		logic              strap_done;
		logic [2:0]        clk_sync;
		logic [2:0]        clk_div;
		logic              clk_prev;
		logic [CW-1:0]     tx_cnt;
		logic [CW-1:0]     rx_cnt;
		logic [CW-1:0]     any_cnt;
		cfm_pins_type      pins;
	} cfm_state_type;

	cfm_state_type st_r;
	cfm_state_type st_nxt;

	function automatic logic [CW-1:0] led_count(input logic [CW-1:0] cnt, input logic hit);
		if (hit)
			led_count = CW'(LED_PULSE_CYCLES); // [RQ15]
		else if (cnt != '0)
			led_count = cnt - CW'(1);
		else
			led_count = '0;
	endfunction : led_count

	function automatic logic legal_sel(input cfm_sel_type s, input int idx);
		if (s == `CFM_SEL_GPIO || s == `CFM_SEL_RD_STB)
			legal_sel = (idx < `CFM_NUM_GPIO_PINS); // [RQ10] [RQ12]
		else if (s == `CFM_SEL_WR_STB)
			legal_sel = (idx < `CFM_NUM_WR_PINS); // [RQ12]
		else
			legal_sel = (s <= `CFM_SEL_CLOCK_OUT_6M); // [RQ2]
	endfunction : legal_sel

	always_comb begin
		logic      stable_clk;
		logic      any_hit;
		logic      drive;
		logic      level;
		logic [4:0] div_clk;
		cfm_sel_type s;
		stable_clk = 1'b0;
		any_hit    = 1'b0;
		drive      = 1'b0;
		level      = 1'b1;
		div_clk    = '0;
		s          = '0;
		st_nxt     = st_r;
		// Latch the stored selections once, then never change at runtime
		if (nvm_valid && !st_r.strap_done) begin
			st_nxt.sel[0]     = nvm_pin_select[0*`CFM_SEL_W +: `CFM_SEL_W]; // [RQ1]
			st_nxt.sel[1]     = nvm_pin_select[1*`CFM_SEL_W +: `CFM_SEL_W];
			st_nxt.sel[2]     = nvm_pin_select[2*`CFM_SEL_W +: `CFM_SEL_W];
			st_nxt.sel[3]     = nvm_pin_select[3*`CFM_SEL_W +: `CFM_SEL_W];
			st_nxt.sel[4]     = nvm_pin_select_4[`CFM_SEL_W-1:0];
			st_nxt.strap_done = 1'b1;
		end
		// Three-stage sync of 48 MHz pin; edge counted when stages 2 and 3 agree
		st_nxt.clk_sync = {st_r.clk_sync[1:0], clock_in_48m};
		stable_clk = st_r.clk_prev;
		if (st_r.clk_sync[2] == st_r.clk_sync[1])
			stable_clk = st_r.clk_sync[2];
		st_nxt.clk_prev = stable_clk;
		if (stable_clk && !st_r.clk_prev)
			st_nxt.clk_div = st_r.clk_div + 3'h1; // [RQ9]
		div_clk = {st_r.clk_div[2], st_r.clk_div[1], st_r.clk_div[0], stable_clk, 1'b0};
		any_hit = usb_tx_event || usb_rx_event;
		st_nxt.tx_cnt  = led_count(st_r.tx_cnt, usb_tx_event);
		st_nxt.rx_cnt  = led_count(st_r.rx_cnt, usb_rx_event);
		st_nxt.any_cnt = led_count(st_r.any_cnt, any_hit);
		for (int i = 0; i < `CFM_NUM_PINS; i++) begin
			s     = st_r.sel[i];
			drive = legal_sel(s, i);
			level = 1'b1;
			case (s)
				`CFM_SEL_LINE_EN:  level = uart_tx_active; // [RQ3]
				`CFM_SEL_POWER_EN: level = !(usb_configured && !usb_suspend); // [RQ4]
				`CFM_SEL_TX_LED:   level = (st_r.tx_cnt == '0); // [RQ5]
				`CFM_SEL_RX_LED:   level = (st_r.rx_cnt == '0); // [RQ6]
				`CFM_SEL_TXRX_LED: level = (st_r.any_cnt == '0); // [RQ7]
				`CFM_SEL_SLEEP:    level = !usb_suspend; // [RQ8]
				`CFM_SEL_CLOCK_OUT_48M:    level = div_clk[1]; // [RQ9]
				`CFM_SEL_CLOCK_OUT_24M:    level = div_clk[2];
				`CFM_SEL_CLOCK_OUT_12M:    level = div_clk[3];
				`CFM_SEL_CLOCK_OUT_6M:     level = div_clk[4];
				`CFM_SEL_GPIO: begin
					if (i < `CFM_NUM_GPIO_PINS) begin
						level = gpio_out[i[1:0]]; // [RQ11]
						drive = gpio_oe[i[1:0]];
					end
				end
				`CFM_SEL_WR_STB:   level = parallel_wr_n; // [RQ12]
				`CFM_SEL_RD_STB:   level = parallel_rd_n; // [RQ12]
				default:           drive = 1'b0;
			endcase
			if (usb_suspend && s != `CFM_SEL_POWER_EN && s != `CFM_SEL_SLEEP)
				drive = 1'b0;
			st_nxt.pins.pin_out[i] = level;
			st_nxt.pins.pin_oe[i]  = drive;
			// Weak pulls only apply while suspended and undriven
			st_nxt.pins.pin_pull_up[i]   = usb_suspend && !drive && !nvm_suspend_pull_low; // [RQ14]
			st_nxt.pins.pin_pull_down[i] = usb_suspend && !drive && nvm_suspend_pull_low; // [RQ14]
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r             <= '0;
			st_r.sel[0]      <= `CFM_DEF_PIN0; // [RQ13]
			st_r.sel[1]      <= `CFM_DEF_PIN1; // [RQ13]
			st_r.sel[2]      <= `CFM_DEF_PIN2;
			st_r.sel[3]      <= `CFM_DEF_PIN3; // [RQ13]
			st_r.sel[4]      <= `CFM_DEF_PIN4;
			st_r.pins.pin_out <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_out       = st_r.pins.pin_out;
	assign pin_oe        = st_r.pins.pin_oe;
	assign pin_pull_up   = st_r.pins.pin_pull_up;
	assign pin_pull_down = st_r.pins.pin_pull_down;
endmodule : cfm_pin_mux

// ==== src/cfm_cfg.svh ====
// Constants for the configurable I/O pin function multiplexer.
// Assumes a 48 MHz internal function clock input alongside the block clock.
`ifndef CFM_CFG_SVH
`define CFM_CFG_SVH
`define CFM_NUM_PINS       5
`define CFM_NUM_GPIO_PINS  4
`define CFM_NUM_WR_PINS    2
`define CFM_SEL_W          4
`define CFM_SEL_LINE_EN    4'h0
`define CFM_SEL_POWER_EN   4'h1
`define CFM_SEL_TX_LED     4'h2
`define CFM_SEL_RX_LED     4'h3
`define CFM_SEL_TXRX_LED   4'h4
`define CFM_SEL_SLEEP      4'h5
`define CFM_SEL_CLOCK_OUT_48M      4'h6
`define CFM_SEL_CLOCK_OUT_24M      4'h7
`define CFM_SEL_CLOCK_OUT_12M      4'h8
`define CFM_SEL_CLOCK_OUT_6M       4'h9
`define CFM_SEL_GPIO       4'hA
`define CFM_SEL_WR_STB     4'hB
`define CFM_SEL_RD_STB     4'hC
`define CFM_DEF_PIN0       4'h2
`define CFM_DEF_PIN1       4'h3
`define CFM_DEF_PIN2       4'h0
`define CFM_DEF_PIN3       4'h1
`define CFM_DEF_PIN4       4'h5
`define CFM_LED_PULSE_NS   50000000
`define CFM_CLK_NS         8
`endif

// ==== src/cfm_pkg.sv ====
// Types for the configurable I/O pin function multiplexer.
// Assumes cfm_cfg.svh supplies every constant.
`include "cfm_cfg.svh"
package cfm_pkg;
	typedef logic [`CFM_SEL_W-1:0] cfm_sel_type;
	typedef struct packed {
		logic [`CFM_NUM_PINS-1:0] pin_out;
		logic [`CFM_NUM_PINS-1:0] pin_oe;
		logic [`CFM_NUM_PINS-1:0] pin_pull_up;
		logic [`CFM_NUM_PINS-1:0] pin_pull_down;
	} cfm_pins_type;
endpackage : cfm_pkg

// ==== tb/cfm_pad_model.sv ====
// Far-side pad model: ideal loads, pull-up on every line.
// Assumes the pin vectors arrive as one carrier struct.
`timescale 1ns/100ps
module cfm_pad_model
	import cfm_pkg::*;
(
	input  wire cfm_pins_type pins,
	output logic [4:0]        pad
);
	// Driven pins show their level, undriven ones go to the pull
	assign pad = (pins.pin_oe & pins.pin_out) | (~pins.pin_oe & ~pins.pin_pull_down);
endmodule : cfm_pad_model

// ==== tb/cfm_pin_mux_assertions.sv ====
// Checker of the pin multiplexer while factory selections hold.
// Assumes it is bound to cfm_pin_mux and sees only its ports.
`timescale 1ns/100ps
module cfm_pin_mux_assertions (
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic       nvm_valid,
	input wire logic       nvm_suspend_pull_low,
	input wire logic       uart_tx_active,
	input wire logic       usb_configured,
	input wire logic       usb_suspend,
	input wire logic       usb_tx_event,
	input wire logic       usb_rx_event,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] pin_pull_up,
	input wire logic [4:0] pin_pull_down
);
	logic lat_r;
	logic run_r;
	wire  dflt = !lat_r && run_r;
	always_ff @(posedge clock) begin
		lat_r <= reset_n && (lat_r || nvm_valid);
		run_r <= reset_n;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	power_on_a: assert property (dflt && $past(usb_configured && !usb_suspend)
		|-> !pin_out[3]) else $error("power pin not low");
	power_off_a: assert property (dflt && $past(usb_suspend) |-> pin_out[3])
		else $error("power pin not high");
	sleep_low_a: assert property (dflt && $past(usb_suspend)
		|-> !pin_out[4] && pin_oe[4]) else $error("sleep pin not low");
	sleep_high_a: assert property (dflt && !$past(usb_suspend) |-> pin_out[4])
		else $error("sleep pin not high");
	line_en_a: assert property (dflt && !$past(usb_suspend)
		|-> pin_out[2] == $past(uart_tx_active)) else $error("line enable wrong");
	tx_led_a: assert property (dflt && usb_tx_event && !usb_suspend
		|-> ##3 !pin_out[0]) else $error("tx led no pulse");
	rx_led_a: assert property (dflt && usb_rx_event && !usb_suspend
		|-> ##3 !pin_out[1]) else $error("rx led no pulse");
	pull_sel_a: assert property (dflt && $past(usb_suspend) |-> !pin_oe[0] &&
		pin_pull_down[0] == $past(nvm_suspend_pull_low) && pin_pull_up[0] != pin_pull_down[0])
		else $error("suspend pull wrong");
endmodule : cfm_pin_mux_assertions
bind cfm_pin_mux cfm_pin_mux_assertions chk_i (.*);

// ==== tb/cfm_pin_mux_tb.sv ====
// Self-checking bench for the pin function multiplexer.
// Assumes an LED pulse count of 8 and the pull-up pad model.
`timescale 1ns/100ps
module cfm_pin_mux_tb
	import cfm_pkg::*;
;
	logic clock = 0, reset_n = 0, nvm_valid = 0, nvm_suspend_pull_low = 0, clock_in_48m = 0;
	logic uart_tx_active = 0, usb_configured = 0, usb_suspend = 0, usb_tx_event = 0;
	logic usb_rx_event = 0, parallel_wr_n = 1, parallel_rd_n = 1;
	logic [15:0] nvm_pin_select = 0;
	logic [4:0] nvm_pin_select_4 = 0, pin_out, pin_oe, pin_pull_up, pin_pull_down, pad;
	logic [3:0] gpio_out = 0, gpio_oe = 0;
	int n_mismatch = 0, checks_done = 0;
	cfm_pin_mux #(.LED_PULSE_CYCLES(8)) uut (.*);
	cfm_pad_model pads (.pins({pin_out, pin_oe, pin_pull_up, pin_pull_down}), .pad(pad));
	initial forever #4 clock = !clock;
	initial forever #10.4 clock_in_48m = !clock_in_48m;
	task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	task automatic end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// Two events 7 cycles apart, then the pin must stay low and recover
	task automatic led(input logic rx, input int idx);
		repeat (2) begin
			usb_tx_event <= !rx;
			usb_rx_event <= rx;
			wt(1);
			usb_tx_event <= 0;
			usb_rx_event <= 0;
			wt(6);
		end
		chk(pin_out[idx], 0);
		wt(12);
		chk(pin_out[idx], 1);
	endtask : led
	// Factory selections, suspend and pulls
	task automatic factory();
		usb_configured <= 1;
		uart_tx_active <= 1;
		wt(4);
		chk({pad[4], pin_out[3:2]}, 3'h5);
		led(0, 0);
		led(1, 1);
		usb_suspend <= 1;
		wt(4);
		chk({pad[4:3], pin_oe[0], pin_pull_up[0]}, 5'h05);
		nvm_suspend_pull_low <= 1;
		wt(3);
		chk({pin_pull_down[0], pad[0]}, 5'h02);
	endtask : factory
	// Stored selections: combined LED, write strobe, refused strobe, GPIO, 6 MHz
	task automatic stored();
		int tg;
		logic prev;
		tg = 0;
		prev = 1'b0;
		reset_n <= 0;
		usb_suspend <= 0;
		nvm_pin_select <= 16'hABB4;
		nvm_pin_select_4 <= 5'h19;
		wt(3);
		reset_n <= 1;
		nvm_valid <= 1;
		gpio_out <= 4'h8;
		gpio_oe <= 4'hF;
		parallel_wr_n <= 0;
		wt(4);
		chk({pin_oe[2], pin_out[3], pin_out[1]}, 5'h02);
		nvm_pin_select <= 16'h0000;
		led(1, 0);
		chk(pin_out[1], 0);
		prev = pin_out[4];
		for (int i = 0; i < 256; i++) begin
			wt(1);
			tg += int'(pin_out[4] != prev);
			prev = pin_out[4];
		end
		chk(pad[4], pin_out[4]);
		chk(tg > 0 && tg < 26, 1);
	endtask : stored
	// Read strobe on pin 2 after a fresh reset
	task automatic strobe();
		reset_n <= 0;
		nvm_pin_select <= 16'h1C00;
		wt(3);
		reset_n <= 1;
		parallel_rd_n <= 0;
		wt(4);
		chk({pin_oe[2], pin_out[2]}, 5'h02);
		parallel_rd_n <= 1;
		wt(2);
		chk({pin_oe[2], pin_out[2]}, 5'h03);
	endtask : strobe
	initial begin
		wt(3);
		reset_n <= 1;
		factory();
		stored();
		strobe();
		end_sim();
	end
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
endmodule : cfm_pin_mux_tb
